/* File: design/asp_pkg.sv */
// Constants and types shared by the serial register port of a quad converter.
// Assumes one core clock domain and one serial clock domain supplied by the host.
// Notes on behaviour
// - Writes to read-only indices and reads of write-only ones are dropped.
// - Writes to the idle indices or the reserved index change nothing.
// - Reads of index 0, 6 or 7 return conversion results next frame.
// - Plain frames are 16 serial clocks, most significant bit first.
// - Bit 15 is direction, bits 14 to 12 index, bits 11 to 0 payload.
// - A write to the primary or upper limit index loads the 12 payload bits.
// - A read of a valid index shifts that register out on lane A next frame.
// - Primary bit 11 picks input pair 0 or 1 for all converters.
// - Primary bit 10 set makes conversions alternate between both pairs.
// - Primary bit 9 picks block averaging or rolling averaging.
// - Ratio bits 8 to 6 decode 2x to 32x; rolling allows 2x to 8x.
// - Changing the write-check bit needs a valid checksum, else frame is dropped.
// - Primary bit 4 enables a checksum on outgoing data.
// - Bit 3 routes the shared pin to lane D or flag, only in lane mode 01.
// - Bit 2 adds two result bits, ignored when the ratio is off.
// - Primary bit 1 picks internal or external voltage reference.
// - Primary bit 0 selects normal operation or shutdown.
// - Secondary bits 9 to 8: 00 lanes A and B, 01 or 11 A, 10 all four.
// - Code 0x3c clears fault flags except setup fault and flushes averaging, registers kept.
// - Code 0xff restores every register default; other codes do nothing.
// - Secondary bits 11 and 10 are read-only and read as zero.
// - With write check on, or on a primary write that turns it on, write frames are 24 bits; otherwise 16.
// - Checksums use generator x^8+x^2+x+1.
// - A checksum-rejected write sets sticky fault bit 9, cleared by reading it.
package asp_pkg;
	localparam logic [2:0]  IDX_NOP0        = 3'h0;
	localparam logic [2:0]  IDX_PRIMARY     = 3'h1;
	localparam logic [2:0]  IDX_SECONDARY   = 3'h2;
	localparam logic [2:0]  IDX_FAULT       = 3'h3;
	localparam logic [2:0]  IDX_LOWER       = 3'h4;
	localparam logic [2:0]  IDX_UPPER       = 3'h5;
	localparam int          DIR_BIT         = 15;
	localparam int          IDX_HI          = 14;
	localparam int          IDX_LO          = 12;
	localparam int          PAIR_BIT        = 11;
	localparam int          ALT_BIT         = 10;
	localparam int          STYLE_BIT       = 9;
	localparam int          RATIO_HI        = 8;
	localparam int          RATIO_LO        = 6;
	localparam int          WCHK_BIT        = 5;
	localparam int          RCHK_BIT        = 4;
	localparam int          FLAGPIN_BIT     = 3;
	localparam int          BOOST_BIT       = 2;
	localparam int          VREF_BIT        = 1;
	localparam int          SHDN_BIT        = 0;
	localparam int          LANE_HI         = 9;
	localparam int          LANE_LO         = 8;
	localparam int          CODE_HI         = 7;
	localparam int          WCHK_FAULT_BIT  = 9;
	localparam int          SETUP_FAULT_BIT = 8;
	localparam logic [11:0] PRIMARY_RST     = 12'h000;
	localparam logic [1:0]  LANE_RST        = 2'h0;
	localparam logic [11:0] FAULT_RST       = 12'h000;
	localparam logic [11:0] LOWER_RST       = 12'h800;
	localparam logic [11:0] UPPER_RST       = 12'h7ff;
	localparam logic [7:0]  SOFT_CODE       = 8'h3c;
	localparam logic [7:0]  HARD_CODE       = 8'hff;
	localparam logic [1:0]  LANE_AB         = 2'h0;
	localparam logic [1:0]  LANE_A          = 2'h1;
	localparam logic [1:0]  LANE_ALL        = 2'h2;
	localparam logic [2:0]  RATIO_OFF       = 3'h0;
	localparam logic [2:0]  RATIO_MAX       = 3'h5;
	localparam logic [2:0]  ROLL_MAX        = 3'h3;
	localparam logic [4:0]  LAST_PLAIN      = 5'h0f;
	localparam logic [4:0]  LAST_CHECKED    = 5'h17;
	localparam logic [7:0]  CHECK_POLY      = 8'h07;
	localparam logic [15:0] CONV_IDLE_WORD  = 16'h0000;
	localparam logic [3:0]  LOWER_FILL      = 4'h0;
	localparam logic [3:0]  UPPER_FILL      = 4'hf;

	// Link side state, clocked by the serial clock.
	typedef struct packed {
		logic [4:0]  count;
		logic [23:0] shift;
		logic [23:0] word;
		logic        word_len24;
		logic        frame_tgl;
		logic [15:0] out_shift;
		logic        lane_a;
		logic        taken_tgl;
	} asp_link_t;
endpackage : asp_pkg

/* File: design/asp_link.sv */
// Serial shifter of the register port, clocked by the host serial clock.
// Assumes inputs change only on falling serial edges or between frames.
module asp_link (
	input  wire logic        sclk,
	input  wire logic        reset,
	input  wire logic        cs_n,
	input  wire logic        serial_in_line,
	input  wire logic        check_on,
	input  wire logic [15:0] reply_word,
	input  wire logic        reply_tgl,
	output logic      [23:0] frame_word,
	output logic             frame_len24,
	output logic             frame_tgl,
	output logic             lane_a_out
);
	asp_pkg::asp_link_t s;
	asp_pkg::asp_link_t next_s;
	logic [23:0]        sh;
	logic [15:0]        src;
	logic               len24;

	// Shift in on every rising edge inside a frame; close the frame at 16 or 24 bits.
	always_comb begin
		next_s = s;
		sh     = {s.shift[22:0], serial_in_line};
		src    = asp_pkg::CONV_IDLE_WORD;
		// Long frames: writes while checking, or a write that turns checking on.
		len24  = sh[asp_pkg::DIR_BIT] & (check_on | ((sh[asp_pkg::IDX_HI:asp_pkg::IDX_LO] == asp_pkg::IDX_PRIMARY)
			& sh[asp_pkg::WCHK_BIT]));
		if (!cs_n) begin
			next_s.shift = sh;
			if (s.count == 5'h00) begin
				// Reply words are quasi-static: main changes them only between frames.
				if (reply_tgl != s.taken_tgl) begin
					src              = reply_word;
					next_s.taken_tgl = reply_tgl;
				end
				next_s.lane_a    = src[15];
				next_s.out_shift = {src[14:0], 1'b0};
			end else begin
				next_s.lane_a    = s.out_shift[15];
				next_s.out_shift = {s.out_shift[14:0], 1'b0};
			end
			if ((s.count == asp_pkg::LAST_PLAIN && !len24) || s.count == asp_pkg::LAST_CHECKED) begin
				next_s.word       = sh;
				next_s.word_len24 = (s.count == asp_pkg::LAST_CHECKED);
				next_s.frame_tgl  = ~s.frame_tgl;
				next_s.count      = 5'h00;
			end else begin
				next_s.count = s.count + 5'h01;
			end
		end
	end

	// Link register; frames shorter than the rule length are not supported.
	always_ff @(posedge sclk or posedge reset) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign frame_word  = s.word;
	assign frame_len24 = s.word_len24;
	assign frame_tgl   = s.frame_tgl;
	assign lane_a_out  = s.lane_a;
endmodule : asp_link

/* File: design/asp_regport.sv */
// Register bank and frame decoder of the serial configuration port.
// Assumes a 125 MHz core clock, a host-driven serial clock and frames
// separated by at least six core clock cycles of idle chip select.
module asp_regport (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        serial_in_line,
	input  wire logic [7:0]  alert_events,
	input  wire logic        setup_fault,
	input  wire logic        conv_strobe,
	output logic             lane_a_out,
	output logic             input_pair_pick,
	output logic             pair_alternator,
	output logic             active_pair,
	output logic             averaging_style,
	output logic [2:0]       averaging_ratio,
	output logic             average_done,
	output logic             read_check_en,
	output logic             lane_d_flag_sel,
	output logic             width_boost,
	output logic             voltage_source_pick,
	output logic             shutdown_select,
	output logic [1:0]       output_lane_config,
	output logic [3:0]       lane_enable,
	output logic [15:0]      lower_limit_full,
	output logic [15:0]      upper_limit_full,
	output logic             soft_reset_pulse,
	output logic             hard_reset_pulse
);
	// Core side state held in one record.
	typedef struct packed {
		logic        tgl_meta;
		logic        tgl_sync;
		logic        tgl_seen;
		logic [11:0] config_primary;
		logic [1:0]  lane_cfg;
		logic [11:0] fault_flags;
		logic [11:0] lower_limit;
		logic [11:0] upper_limit;
		logic [15:0] reply_word;
		logic        reply_tgl;
		logic [2:0]  eff_ratio;
		logic        eff_boost;
		logic        flag_sel;
		logic [3:0]  lanes;
		logic        pair;
		logic [5:0]  avg_count;
		logic        avg_done;
		logic        soft_pulse;
		logic        hard_pulse;
	} asp_main_t;

	asp_main_t   s;
	asp_main_t   next_s;
	logic [23:0] frame_word;
	logic        frame_len24;
	logic        frame_tgl;
	logic [15:0] cmd;
	logic [7:0]  sum;
	logic [2:0]  idx;
	logic [11:0] data;
	logic        new_frame;
	logic        accepted;
	logic [11:0] pri;
	logic [5:0]  avg_len;

	// Checksum over the sixteen command bits, most significant bit first.
	function automatic logic [7:0] check8(input logic [15:0] bits);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 15; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ bits[i]) ? asp_pkg::CHECK_POLY : 8'h00);
		end
		return c;
	endfunction : check8

	// True for indices that hold a real register.
	function automatic logic idx_real(input logic [2:0] i);
		return (i >= asp_pkg::IDX_PRIMARY) && (i <= asp_pkg::IDX_UPPER);
	endfunction : idx_real

	// Averaging depth in samples for a ratio code, one for disabled.
	function automatic logic [5:0] ratio_len(input logic [2:0] r);
		return (r == asp_pkg::RATIO_OFF) ? 6'h01 : 6'(6'h01 << r);
	endfunction : ratio_len

	// Serial side shifter.
	asp_link u_link (
		.sclk           (sclk),
		.reset          (reset),
		.cs_n           (cs_n),
		.serial_in_line (serial_in_line),
		.check_on       (s.config_primary[asp_pkg::WCHK_BIT]),
		.reply_word     (s.reply_word),
		.reply_tgl      (s.reply_tgl),
		.frame_word     (frame_word),
		.frame_len24    (frame_len24),
		.frame_tgl      (frame_tgl),
		.lane_a_out     (lane_a_out)
	);

	// Split the captured frame into command and checksum.
	always_comb begin
		cmd       = frame_len24 ? frame_word[23:8] : frame_word[15:0];
		sum       = frame_len24 ? frame_word[7:0] : 8'h00;
		idx       = cmd[asp_pkg::IDX_HI:asp_pkg::IDX_LO];
		data      = cmd[11:0];
		new_frame = s.tgl_sync != s.tgl_seen;
	end

	// Decode frames, keep registers, sticky flags and derived controls.
	always_comb begin
		next_s            = s;
		next_s.tgl_meta   = frame_tgl;
		next_s.tgl_sync   = s.tgl_meta;
		next_s.tgl_seen   = s.tgl_sync;
		next_s.soft_pulse = 1'b0;
		next_s.hard_pulse = 1'b0;
		next_s.avg_done   = 1'b0;
		accepted          = 1'b0;
		// The word is only used once the whole frame has crossed over.
		if (new_frame) begin
			if (cmd[asp_pkg::DIR_BIT]) begin
				if (frame_len24) begin
					accepted = check8(cmd) == sum;
				end else begin
					// A short frame may not flip the write-check bit.
					accepted = !(idx == asp_pkg::IDX_PRIMARY
						&& data[asp_pkg::WCHK_BIT] != s.config_primary[asp_pkg::WCHK_BIT]);
				end
				if (!accepted) begin
					next_s.fault_flags[asp_pkg::WCHK_FAULT_BIT] = 1'b1;
				end else if (idx == asp_pkg::IDX_PRIMARY) begin
					next_s.config_primary = data;
				end else if (idx == asp_pkg::IDX_SECONDARY) begin
					next_s.lane_cfg = data[asp_pkg::LANE_HI:asp_pkg::LANE_LO];
					if (data[asp_pkg::CODE_HI:0] == asp_pkg::HARD_CODE) begin
						next_s.config_primary = asp_pkg::PRIMARY_RST;
						next_s.lane_cfg       = asp_pkg::LANE_RST;
						next_s.fault_flags    = asp_pkg::FAULT_RST;
						next_s.lower_limit    = asp_pkg::LOWER_RST;
						next_s.upper_limit    = asp_pkg::UPPER_RST;
						next_s.pair           = 1'b0;
						next_s.avg_count      = 6'h00;
						next_s.hard_pulse     = 1'b1;
					end else if (data[asp_pkg::CODE_HI:0] == asp_pkg::SOFT_CODE) begin
						// Setup fault survives a soft reset; only a hard one clears it.
						next_s.fault_flags = s.fault_flags & (12'h001 << asp_pkg::SETUP_FAULT_BIT);
						next_s.pair        = 1'b0;
						next_s.avg_count   = 6'h00;
						next_s.soft_pulse  = 1'b1;
					end
				end else if (idx == asp_pkg::IDX_UPPER) begin
					next_s.upper_limit = data;
				end
				// Fault, lower limit, idle and reserved indices fall through untouched.
			end else if (idx_real(idx)) begin
				// Read request: queue the register for the next frame on lane A.
				next_s.reply_tgl = ~s.reply_tgl;
				if (idx == asp_pkg::IDX_PRIMARY) begin
					next_s.reply_word = {1'b0, idx, s.config_primary};
				end else if (idx == asp_pkg::IDX_SECONDARY) begin
					next_s.reply_word = {1'b0, idx, 2'b00, s.lane_cfg, 8'h00};
				end else if (idx == asp_pkg::IDX_FAULT) begin
					next_s.reply_word  = {1'b0, idx, s.fault_flags};
					next_s.fault_flags = s.fault_flags & (12'h001 << asp_pkg::SETUP_FAULT_BIT);
				end else if (idx == asp_pkg::IDX_LOWER) begin
					next_s.reply_word = {1'b0, idx, s.lower_limit};
				end else begin
					next_s.reply_word = {1'b0, idx, s.upper_limit};
				end
			end
			// Reads of idle or reserved indices queue nothing: conversions follow.
		end

		// Events set after any clear, so a flag raised while being read is kept.
		next_s.fault_flags[7:0] = next_s.fault_flags[7:0] | alert_events;
		next_s.fault_flags[asp_pkg::SETUP_FAULT_BIT] = next_s.fault_flags[asp_pkg::SETUP_FAULT_BIT]
			| setup_fault;

		// Derived controls from the updated primary register.
		pri = next_s.config_primary;
		if (pri[asp_pkg::RATIO_HI:asp_pkg::RATIO_LO] > asp_pkg::RATIO_MAX) begin
			next_s.eff_ratio = asp_pkg::RATIO_OFF;
		end else if (pri[asp_pkg::STYLE_BIT] && pri[asp_pkg::RATIO_HI:asp_pkg::RATIO_LO] > asp_pkg::ROLL_MAX) begin
			next_s.eff_ratio = asp_pkg::RATIO_OFF;
		end else begin
			next_s.eff_ratio = pri[asp_pkg::RATIO_HI:asp_pkg::RATIO_LO];
		end
		next_s.eff_boost = pri[asp_pkg::BOOST_BIT] && next_s.eff_ratio != asp_pkg::RATIO_OFF;
		next_s.flag_sel  = pri[asp_pkg::FLAGPIN_BIT] && next_s.lane_cfg == asp_pkg::LANE_A;

		// Lane enables: bit 0 is lane A up to bit 3 for lane D.
		if (next_s.lane_cfg == asp_pkg::LANE_AB) begin
			next_s.lanes = 4'h3;
		end else if (next_s.lane_cfg == asp_pkg::LANE_ALL) begin
			next_s.lanes = 4'hf;
		end else begin
			next_s.lanes = 4'h1;
		end

		// Pair selection steps on each conversion while alternation is on, except in a soft or hard reset pulse cycle.
		if (!pri[asp_pkg::ALT_BIT]) begin
			next_s.pair = pri[asp_pkg::PAIR_BIT];
		end else if (conv_strobe && !next_s.soft_pulse && !next_s.hard_pulse) begin
			next_s.pair = ~s.pair;
		end

		// Averaging counter, flushed by a soft or hard reset above.
		avg_len = ratio_len(next_s.eff_ratio);
		if (conv_strobe && !next_s.soft_pulse && !next_s.hard_pulse && !pri[asp_pkg::SHDN_BIT]) begin
			if (pri[asp_pkg::STYLE_BIT] && next_s.eff_ratio != asp_pkg::RATIO_OFF) begin
				// Rolling averages give a result every sample once the window is full.
				next_s.avg_done  = (s.avg_count + 6'h01) >= avg_len;
				next_s.avg_count = next_s.avg_done ? (avg_len - 6'h01) : (s.avg_count + 6'h01);
			end else if ((s.avg_count + 6'h01) >= avg_len) begin
				next_s.avg_done  = 1'b1;
				next_s.avg_count = 6'h00;
			end else begin
				next_s.avg_count = s.avg_count + 6'h01;
			end
		end
	end

	// Core register with asynchronous reset to documented defaults.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s                <= '0;
			s.config_primary <= asp_pkg::PRIMARY_RST;
			s.lane_cfg       <= asp_pkg::LANE_RST;
			s.fault_flags    <= asp_pkg::FAULT_RST;
			s.lower_limit    <= asp_pkg::LOWER_RST;
			s.upper_limit    <= asp_pkg::UPPER_RST;
			s.lanes          <= 4'h3;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the core register.
	assign input_pair_pick     = s.config_primary[asp_pkg::PAIR_BIT];
	assign pair_alternator     = s.config_primary[asp_pkg::ALT_BIT];
	assign active_pair         = s.pair;
	assign averaging_style     = s.config_primary[asp_pkg::STYLE_BIT];
	assign averaging_ratio     = s.eff_ratio;
	assign average_done        = s.avg_done;
	assign read_check_en       = s.config_primary[asp_pkg::RCHK_BIT];
	assign lane_d_flag_sel     = s.flag_sel;
	assign width_boost         = s.eff_boost;
	assign voltage_source_pick = s.config_primary[asp_pkg::VREF_BIT];
	assign shutdown_select     = s.config_primary[asp_pkg::SHDN_BIT];
	assign output_lane_config  = s.lane_cfg;
	assign lane_enable         = s.lanes;
	assign lower_limit_full    = {s.lower_limit, asp_pkg::LOWER_FILL};
	assign upper_limit_full    = {s.upper_limit, asp_pkg::UPPER_FILL};
	assign soft_reset_pulse    = s.soft_pulse;
	assign hard_reset_pulse    = s.hard_pulse;
endmodule : asp_regport

/* File: dv/asp_host.sv */
// Host controller model that frames commands for the serial register port.
// Assumes the bench leaves at least 48 ns of idle chip select between frames.
module asp_host (
	output logic      sclk,
	output logic      cs_n,
	output logic      serial_in_line,
	input  wire logic lane_a_out
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam real HALF = 24.0;

	// Serial clock rests low and chip select high outside frames.
	initial begin
		sclk           = 1'b0;
		cs_n           = 1'b1;
		serial_in_line = 1'b0;
	end

	// Checksum over the command word, most significant bit first, zero start.
	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction : crc8

	// One frame: data changes on falling edges, the reply is taken there too.
	task automatic send(input logic [15:0] cmd, input logic lng, input logic bad, output logic [15:0] rx);
		logic [23:0] w;
		int          n;
		w = {cmd, crc8(cmd) ^ {7'h00, bad}};
		n = lng ? 24 : 16;
		#5.3;
		cs_n           = 1'b0;
		serial_in_line = w[23];
		#(HALF);
		for (int i = 0; i < n; i++) begin
			sclk = 1'b1;
			#(HALF);
			sclk = 1'b0;
			if (i < 16) rx[15 - i] = lane_a_out;
			if (i < n - 1) serial_in_line = w[22 - i];
			#(HALF);
		end
		cs_n           = 1'b1;
		serial_in_line = ~serial_in_line;
	endtask : send
endmodule : asp_host

/* File: dv/asp_regport_properties.sv */
// Concurrent checks on the settings ports of the register port.
// Assumes every watched port belongs to the core clock domain.
module asp_regport_properties (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        conv_strobe,
	input wire logic        input_pair_pick,
	input wire logic        pair_alternator,
	input wire logic        active_pair,
	input wire logic        averaging_style,
	input wire logic [2:0]  averaging_ratio,
	input wire logic        average_done,
	input wire logic        lane_d_flag_sel,
	input wire logic        width_boost,
	input wire logic        shutdown_select,
	input wire logic [1:0]  output_lane_config,
	input wire logic [3:0]  lane_enable,
	input wire logic [15:0] lower_limit_full,
	input wire logic [15:0] upper_limit_full,
	input wire logic        soft_reset_pulse,
	input wire logic        hard_reset_pulse
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// The checks tie settings outputs to their causes; the gate, decode, ratio, defaults and pair checks add a short guard against skew.
	a_flag_gate: assert property (
		$stable(output_lane_config) && lane_d_flag_sel |-> output_lane_config == 2'h1)
		else $error("flag pin routed outside single lane mode");
	a_lane_decode: assert property (
		$stable(output_lane_config) |-> lane_enable ==
		(output_lane_config == 2'h0 ? 4'h3 : (output_lane_config == 2'h2 ? 4'hf : 4'h1)))
		else $error("lane enables do not match lane mode");
	a_boost_gate: assert property (
		$stable(averaging_ratio) && width_boost |-> averaging_ratio != 3'h0)
		else $error("width boost without averaging");
	a_ratio_range: assert property (
		$stable(averaging_style) ##1 $stable(averaging_style) |->
		averaging_ratio <= (averaging_style ? 3'h3 : 3'h5))
		else $error("averaging ratio outside its mode");
	a_pulse_once: assert property (
		soft_reset_pulse || hard_reset_pulse |=> !soft_reset_pulse && !hard_reset_pulse)
		else $error("reset pulse longer than one cycle");
	a_hard_defaults: assert property (
		hard_reset_pulse |-> ##[0:2] (upper_limit_full == 16'h7fff && lower_limit_full == 16'h8000 &&
		output_lane_config == 2'h0 && !shutdown_select && averaging_ratio == 3'h0))
		else $error("hard reset left settings changed");
	a_pair_fixed: assert property (
		!pair_alternator && $stable(pair_alternator) && $stable(input_pair_pick) |->
		active_pair == input_pair_pick)
		else $error("active pair differs from picked pair");
	a_pair_toggle: assert property (
		pair_alternator && conv_strobe ##1 pair_alternator && !soft_reset_pulse && !hard_reset_pulse |->
		active_pair != $past(active_pair))
		else $error("pair did not alternate on conversion");
	a_done_cause: assert property (
		average_done |-> $past(conv_strobe) && !shutdown_select)
		else $error("averaging done without a conversion");
	a_limit_fill: assert property (
		lower_limit_full[3:0] == 4'h0 && upper_limit_full[3:0] == 4'hf)
		else $error("limit fill bits wrong");

	// Main scenarios reached by the bench.
	c_soft: cover property (soft_reset_pulse);
	c_hard: cover property (hard_reset_pulse);
	c_flag: cover property (lane_d_flag_sel);
	c_boost: cover property (width_boost && averaging_style);
endmodule : asp_regport_properties

bind asp_regport asp_regport_properties asp_regport_properties_inst (.clk(clk), .reset(reset),
	.conv_strobe(conv_strobe), .input_pair_pick(input_pair_pick), .pair_alternator(pair_alternator),
	.active_pair(active_pair), .averaging_style(averaging_style), .averaging_ratio(averaging_ratio),
	.average_done(average_done),
	.lane_d_flag_sel(lane_d_flag_sel), .width_boost(width_boost), .shutdown_select(shutdown_select),
	.output_lane_config(output_lane_config), .lane_enable(lane_enable),
	.lower_limit_full(lower_limit_full), .upper_limit_full(upper_limit_full),
	.soft_reset_pulse(soft_reset_pulse), .hard_reset_pulse(hard_reset_pulse));

/* File: dv/tb_top.sv */
// Self-checking bench: host model frames, a reference model predicts every read reply and settings output.
// Assumes the design files and the host model are compiled first.
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk, reset, sclk, cs_n, serial_in_line, setup_fault, conv_strobe, lane_a_out;
	logic        input_pair_pick, pair_alternator, active_pair, averaging_style, average_done;
	logic        read_check_en, lane_d_flag_sel, width_boost, voltage_source_pick, shutdown_select;
	logic        soft_reset_pulse, hard_reset_pulse, pend_ok;
	logic [7:0]  alert_events, ev;
	logic [2:0]  averaging_ratio;
	logic [1:0]  output_lane_config;
	logic [3:0]  lane_enable;
	logic [15:0] lower_limit_full, upper_limit_full, pend, rx;
	int          mismatches, n_compared, prim, lane, flt, upper;
	int          ro_idx[5] = '{0, 3, 4, 6, 7};

	asp_regport asp_regport_inst (.clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n),
		.serial_in_line(serial_in_line), .alert_events(alert_events), .setup_fault(setup_fault),
		.conv_strobe(conv_strobe), .lane_a_out(lane_a_out), .input_pair_pick(input_pair_pick),
		.pair_alternator(pair_alternator), .active_pair(active_pair), .averaging_style(averaging_style),
		.averaging_ratio(averaging_ratio), .average_done(average_done), .read_check_en(read_check_en),
		.lane_d_flag_sel(lane_d_flag_sel), .width_boost(width_boost),
		.voltage_source_pick(voltage_source_pick), .shutdown_select(shutdown_select),
		.output_lane_config(output_lane_config), .lane_enable(lane_enable),
		.lower_limit_full(lower_limit_full), .upper_limit_full(upper_limit_full),
		.soft_reset_pulse(soft_reset_pulse), .hard_reset_pulse(hard_reset_pulse));
	asp_host asp_host_inst (.sclk(sclk), .cs_n(cs_n), .serial_in_line(serial_in_line), .lane_a_out(lane_a_out));

	// Core clock of 8 ns.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Random conversion strobes keep the pair alternation busy.
	always @(negedge clk) conv_strobe <= ($urandom_range(7) == 0);

	// Stops a hung run and counts it as a mismatch.
	initial begin
		#700us;
		mismatches++;
		print_verdict();
	end

	task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task automatic model_reset();
		prim  = 0;
		lane  = 0;
		flt   = 0;
		upper = 'h7ff;
	endtask : model_reset

	// Predicts every settings output from the model registers.
	task automatic check_ports();
		int r, e;
		r = (prim >> 6) & 7;
		e = (r > 5 || (prim[9] && r > 3)) ? 0 : r;
		cmp("settings", {prim[11], prim[10], prim[9], 3'(e), prim[4], prim[3] && lane == 1, prim[2] && e != 0,
			prim[1], prim[0], 2'(lane), (lane == 0 ? 4'h3 : (lane == 2 ? 4'hf : 4'h1)), 16'h8000,
			16'(upper << 4 | 15)}, {input_pair_pick, pair_alternator, averaging_style, averaging_ratio,
			read_check_en, lane_d_flag_sel, width_boost, voltage_source_pick, shutdown_select,
			output_lane_config, lane_enable, lower_limit_full, upper_limit_full});
	endtask : check_ports

	// Sends one frame, checks the reply of the previous read, then updates the model.
	task automatic frame(input logic [15:0] cmd, input logic bad);
		logic       lng;
		logic [2:0] idx;
		idx = cmd[14:12];
		lng = cmd[15] && (prim[5] || (idx == 3'h1 && cmd[5]));
		asp_host_inst.send(cmd, lng, bad, rx);
		if (pend_ok) cmp("reply", pend, rx);
		pend_ok = !cmd[15];
		pend    = 16'h0000;
		repeat (20) @(negedge clk);
		if (cmd[15] && lng && bad) flt |= 'h200;
		else if (cmd[15]) begin
			if (idx == 3'h1) prim = cmd[11:0];
			if (idx == 3'h5) upper = cmd[11:0];
			if (idx == 3'h2) begin
				lane = cmd[9:8];
				if (cmd[7:0] == 8'h3c) flt &= 'h100;
				if (cmd[7:0] == 8'hff) model_reset();
			end
		end else case (idx)
			3'h1: pend = {4'h1, prim[11:0]};
			3'h2: pend = {6'h08, 2'(lane), 8'h00};
			3'h3: begin
				pend = {4'h3, flt[11:0]};
				flt &= 'h100;
			end
			3'h4: pend = 16'h4800;
			3'h5: pend = {4'h5, upper[11:0]};
			default: pend = 16'h0000;
		endcase
		check_ports();
	endtask : frame

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict

	// Main sequence.
	initial begin
		// Reset rises after time zero so that the idle serial side also sees its edge.
		reset        = 1'b0;
		alert_events = 8'h00;
		setup_fault  = 1'b0;
		mismatches   = 0;
		n_compared   = 0;
		pend_ok      = 1'b0;
		pend         = 16'h0000;
		model_reset();
		void'($urandom(52592));
		#2;
		reset = 1'b1;
		repeat (12) @(negedge clk);
		reset = 1'b0;
		check_ports();
		for (int i = 0; i < 8; i++) frame(16'(i << 12), 1'b0);
		foreach (ro_idx[k]) frame(16'h8fff | 16'(ro_idx[k] << 12), 1'b0);
		for (int i = 0; i < 8; i++) frame(16'(i << 12), 1'b0);
		repeat (60) frame({1'($urandom), 3'($urandom), 12'($urandom) & 12'hfdf}, 1'b0);
		// Write checking refused with a bad checksum, then switched on, used and switched off.
		frame(16'h9020, 1'b1);
		frame(16'h3000, 1'b0);
		frame(16'h9020, 1'b0);
		frame(16'hd5a5, 1'b1);
		frame(16'hd5a5, 1'b0);
		frame(16'h3000, 1'b0);
		frame(16'h9000, 1'b0);
		// Alert and setup faults, then the soft reset, an idle code and the hard reset.
		ev = 8'($urandom) | 8'h01;
		alert_events = ev;
		setup_fault  = 1'b1;
		@(negedge clk);
		alert_events = 8'h00;
		setup_fault  = 1'b0;
		flt |= 'h100 | ev;
		frame(16'h9a5f, 1'b0);
		frame(16'ha13c, 1'b0);
		frame(16'h3000, 1'b0);
		frame(16'ha25a, 1'b0);
		frame(16'h2000, 1'b0);
		frame(16'ha2ff, 1'b0);
		frame(16'h3000, 1'b0);
		frame(16'h1000, 1'b0);
		frame(16'h0000, 1'b0);
		print_verdict();
	end
endmodule : tb_top
